//--- rtl/lam_pkg.sv
// Package: register map, field layout and reset values of the alert logic
package lam_pkg;
  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 8;
  localparam int unsigned PRI_W = 7;
  localparam int unsigned SEC_W = 8;
  // Register offsets
  localparam logic [7:0] ADDR_STATUS_PRI = 8'h41;
  localparam logic [7:0] ADDR_STATUS_SEC = 8'h42;
  localparam logic [7:0] ADDR_MASK_PRI = 8'h74;
  localparam logic [7:0] ADDR_MASK_SEC = 8'h75;
  localparam logic [7:0] ADDR_CFG3 = 8'h78;
  // Field positions
  localparam int unsigned SUMMARY_BIT = 7;
  localparam int unsigned SEC_ENABLE_BIT = 7;
  localparam int unsigned ALERT_SEL_BIT = 0;
  // Reset values and read data of unmapped addresses
  localparam logic [7:0] MASK_PRI_RST = 8'h00;
  localparam logic [7:0] MASK_SEC_RST = 8'h00;
  localparam logic [7:0] CFG3_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
endpackage

//--- rtl/lam_sticky_flags.sv
// Sticky out-of-limit flags for one status register
`timescale 1ns/1ps
`default_nettype none
module lam_sticky_flags #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Condition and read strobe
  input wire logic [W-1:0] cond_i,
  input wire logic rd_clr_i,
  // Flags
  output logic [W-1:0] flags_o
);
  logic [W-1:0] flag_ff;

  // -------------------------------------------------------------
  // Per-bit flag: a live condition always wins over the read clear
  // -------------------------------------------------------------
  for (genvar k = 0; k < W; k++) begin : g_bit
    logic nxt_flag;
    assign nxt_flag = cond_i[k] | (flag_ff[k] & ~rd_clr_i); // [RL1] [RL2] [RL13]
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        flag_ff[k] <= 1'b0;
      end else begin
        flag_ff[k] <= nxt_flag;
      end
    end
  end

  assign flags_o = flag_ff;
endmodule // lam_sticky_flags
`default_nettype wire

//--- rtl/lam_alert_top.sv
// Out-of-limit status flags, alert masks and alert/fan-drive pin sharing
// Function
// (RL1) Out-of-limit channel sets its status flag
// (RL2) Flag holds until condition gone and read
// (RL3) Alert low while unmasked source out-of-limit
// (RL4) Mask gates alert only, flag still sets
// (RL5) Primary mask bit 7 enables secondary mask
// (RL6) Primary mask bits 6..0 map channels
// (RL7) Secondary mask bits map diodes, fans, overtemp, 12V
// (RL8) Host reads status then masks source
// (RL9) Host polls, unmasks once flag clears
// (RL10) Status1 bit 7 summarises status2 flags
// (RL11) Status2 holds diodes, fans, overtemp, 12V
// (RL12) Config3 bit 0 selects alert over fan drive
// (RL13) Read clears only flags whose condition ended
// (RL14) Alert releases when no unmasked flag set
`timescale 1ns/1ps
`default_nettype none
module lam_alert_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Limit comparison results, same clock domain
  input wire logic [lam_pkg::PRI_W-1:0] pri_cond_i,
  input wire logic [lam_pkg::SEC_W-1:0] sec_cond_i,
  // Register port from the serial interface engine
  input wire logic [lam_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [lam_pkg::REG_DW-1:0] reg_wdata_i,
  output logic [lam_pkg::REG_DW-1:0] reg_rdata_o,
  // Shared pin: fan drive or alert
  input wire logic second_fan_drive_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic alert_n_o
);
  logic [lam_pkg::PRI_W-1:0] pri_flags;
  logic [lam_pkg::SEC_W-1:0] sec_flags;
  logic [7:0] mask_pri_ff;
  logic [7:0] mask_sec_ff;
  logic [7:0] cfg3_ff;
  logic [7:0] rdata_ff;
  logic alert_n_ff;
  logic pin_ff;
  logic pin_oe_ff;

  // -------------------------------------------------------------
  // Address decode
  // -------------------------------------------------------------
  wire hit_st_pri = reg_addr_i == lam_pkg::ADDR_STATUS_PRI;
  wire hit_st_sec = reg_addr_i == lam_pkg::ADDR_STATUS_SEC;
  wire hit_mk_pri = reg_addr_i == lam_pkg::ADDR_MASK_PRI;
  wire hit_mk_sec = reg_addr_i == lam_pkg::ADDR_MASK_SEC;
  wire hit_cfg3 = reg_addr_i == lam_pkg::ADDR_CFG3;
  wire rd_st_pri = reg_rd_i & hit_st_pri;
  wire rd_st_sec = reg_rd_i & hit_st_sec;

  // -------------------------------------------------------------
  // Sticky status registers
  // -------------------------------------------------------------
  lam_sticky_flags #(.W(lam_pkg::PRI_W)) u_pri (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .cond_i(pri_cond_i),
    .rd_clr_i(rd_st_pri),
    .flags_o(pri_flags)
  );

  lam_sticky_flags #(.W(lam_pkg::SEC_W)) u_sec (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .cond_i(sec_cond_i),
    .rd_clr_i(rd_st_sec),
    .flags_o(sec_flags)
  );

  // Summary bit is live, so it drops with the last secondary flag
  wire summary = |sec_flags; // [RL10] [RL11]
  wire [7:0] status_pri = {summary, pri_flags}; // [RL10]

  // -------------------------------------------------------------
  // Masking and alert
  // -------------------------------------------------------------
  wire sec_mask_en = mask_pri_ff[lam_pkg::SEC_ENABLE_BIT]; // [RL5]
  wire [lam_pkg::PRI_W-1:0] eff_mask_pri =
    mask_pri_ff[lam_pkg::PRI_W-1:0]; // [RL6]
  wire [lam_pkg::SEC_W-1:0] eff_mask_sec =
    sec_mask_en ? mask_sec_ff : '0; // [RL5] [RL7]
  // Flags drive the alert; masks never touch the flags
  wire pending = |(pri_flags & ~eff_mask_pri) |
                 |(sec_flags & ~eff_mask_sec); // [RL3] [RL4] [RL14]
  wire alert_mode = cfg3_ff[lam_pkg::ALERT_SEL_BIT]; // [RL12]
  // Mask write lands one edge later and may hide a fresh flag
  wire mask_pri_wr = reg_wr_i & hit_mk_pri;

  // -------------------------------------------------------------
  // Register writes and read data
  // -------------------------------------------------------------
  wire [7:0] nxt_rdata =
    hit_st_pri ? status_pri :
    hit_st_sec ? sec_flags :
    hit_mk_pri ? mask_pri_ff :
    hit_mk_sec ? mask_sec_ff :
    hit_cfg3 ? cfg3_ff : lam_pkg::UNMAPPED_RDATA;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask_pri_ff <= lam_pkg::MASK_PRI_RST;
      mask_sec_ff <= lam_pkg::MASK_SEC_RST;
      cfg3_ff <= lam_pkg::CFG3_RST;
    end else if (reg_wr_i) begin
      if (hit_mk_pri) mask_pri_ff <= reg_wdata_i;
      if (hit_mk_sec) mask_sec_ff <= reg_wdata_i;
      if (hit_cfg3) cfg3_ff <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= lam_pkg::RDATA_RST;
    end else if (reg_rd_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // -------------------------------------------------------------
  // Pin drive; alert is open-drain, fan drive is actively driven
  // -------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alert_n_ff <= 1'b1;
      pin_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else begin
      alert_n_ff <= ~pending; // [RL3] [RL14]
      pin_ff <= alert_mode ? 1'b0 : second_fan_drive_i; // [RL12]
      pin_oe_ff <= alert_mode ? pending : 1'b1; // [RL12]
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign alert_n_o = alert_n_ff;
  assign pin_o = pin_ff;
  assign pin_oe_o = pin_oe_ff;

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_flag_set;
    1 |=> ((pri_flags & $past(pri_cond_i)) == $past(pri_cond_i)) &&
          ((sec_flags & $past(sec_cond_i)) == $past(sec_cond_i));
  endproperty
  a_flag_set: assert property (p_flag_set) // [RL1]
    else $error("status flag not set by out-of-limit condition");

  property p_flag_hold;
    1 |=> ((~pri_flags & $past(pri_flags) &
            ($past(pri_cond_i) | {lam_pkg::PRI_W{~$past(rd_st_pri)}})) == '0);
  endproperty
  a_flag_hold: assert property (p_flag_hold) // [RL2]
    else $error("primary flag cleared without read or with live cause");

  property p_sec_hold;
    1 |=> ((~sec_flags & $past(sec_flags) &
            ($past(sec_cond_i) | {lam_pkg::SEC_W{~$past(rd_st_sec)}})) == '0);
  endproperty
  a_sec_hold: assert property (p_sec_hold) // [RL13]
    else $error("secondary flag cleared while cause persisted");

  property p_rd_clears;
    rd_st_pri |=> (pri_flags & ~$past(pri_cond_i)) == '0;
  endproperty
  a_rd_clears: assert property (p_rd_clears) // [RL13]
    else $error("primary flag survived a read with its cause gone");

  property p_alert_low;
    (|(pri_cond_i & ~eff_mask_pri)) && !mask_pri_wr |-> ##2 !alert_n_o;
  endproperty
  a_alert_low: assert property (p_alert_low) // [RL3]
    else $error("alert not low for unmasked out-of-limit source");

  property p_masked_sets;
    (|(pri_cond_i & eff_mask_pri)) |=>
      ((pri_flags & $past(pri_cond_i & eff_mask_pri)) ==
       $past(pri_cond_i & eff_mask_pri));
  endproperty
  a_masked_sets: assert property (p_masked_sets) // [RL4]
    else $error("masked source failed to set its flag");

  property p_sec_enable;
    !sec_mask_en && !mask_pri_wr && (|sec_cond_i) |-> ##2 !alert_n_o;
  endproperty
  a_sec_enable: assert property (p_sec_enable) // [RL5]
    else $error("secondary mask acted while disabled");

  property p_summary;
    reg_rd_i && hit_st_pri |=> reg_rdata_o[lam_pkg::SUMMARY_BIT] ==
                               $past(|sec_flags);
  endproperty
  a_summary: assert property (p_summary) // [RL10]
    else $error("summary bit does not match secondary flags");

  property p_release;
    (!pending) [*2] |-> alert_n_o;
  endproperty
  a_release: assert property (p_release) // [RL14]
    else $error("alert held with no unmasked flag");

  property p_fan_mode;
    !alert_mode ##1 1 |-> pin_oe_o && pin_o == $past(second_fan_drive_i);
  endproperty
  a_fan_mode: assert property (p_fan_mode) // [RL12]
    else $error("pin not following fan drive in default mode");

  c_alert: cover property (alert_mode ##1 !alert_n_o ##[1:20] alert_n_o);
  c_rd_clear: cover property ($fell(pri_flags[0]));
  c_sec_masked: cover property (sec_mask_en && (|(sec_flags & mask_sec_ff)));
endmodule // lam_alert_top
`default_nettype wire

//--- verification/lam_host_model.sv
// Host model: register accesses and alert servicing
`timescale 1ns/1ps
`default_nettype none
module lam_host_model (
  // Clock and alert
  input wire logic clk_i,
  input wire logic alert_n_i,
  // Register port
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  logic [7:0] m1 = 8'h00;
  logic [7:0] m2 = 8'h00;
  logic [7:0] s1;
  logic [7:0] s2;
  initial addr_o = 8'h00;
  initial wr_o = 1'b0;
  initial rd_o = 1'b0;
  initial wdata_o = 8'h00;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i) #1;
    wr_o = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_i) #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i) #1;
    rd_o = 1'b0;
    q = rdata_i;
  endtask
  // Mask flagged sources on alert, unmask cleared ones when polling
  task automatic service();
    logic al;
    al = !alert_n_i;
    rd(8'h41, s1);
    rd(8'h42, s2);
    if (al) begin
      m1 = m1 | {1'b0, s1[6:0]};
      m2 = m2 | s2;
    end else begin
      m1 = m1 & {1'b1, s1[6:0]};
      m2 = m2 & s2;
    end
    m1[7] = |m2;
    wr(8'h74, m1);
    wr(8'h75, m2);
  endtask
endmodule // lam_host_model
`default_nettype wire

//--- verification/lam_alert_top_tb.sv
// Testbench: reference model, directed and random alert traffic
`timescale 1ns/1ps
`default_nettype none
module lam_alert_top_tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [6:0] pri = 7'h00;
  logic [7:0] sec = 8'h00;
  logic fan = 1'b0;
  wire logic [7:0] addr, wdata, rdata;
  wire logic wr, rd, pin, oe, alert_n;
  logic [6:0] f1;
  logic [7:0] f2, k1, k2, k3, e_rd, q, m;
  logic e_al, e_pin, e_oe;
  logic [31:0] r;
  int seed = 93410;
  int err_count = 0;
  int samples_checked = 0;
  initial forever #4 clk_i = ~clk_i;
  lam_alert_top i_lam_alert_top (.clk_i(clk_i), .resetn_i(resetn_i),
    .pri_cond_i(pri), .sec_cond_i(sec), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .second_fan_drive_i(fan), .pin_o(pin), .pin_oe_o(oe),
    .alert_n_o(alert_n));
  lam_host_model i_lam_host_model (.clk_i(clk_i), .alert_n_i(alert_n),
    .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  function automatic logic pend(input logic [6:0] a, input logic [7:0] b);
    return |(a & ~k1[6:0]) | |(b & ~(k1[7] ? k2 : 8'h00));
  endfunction
  // ----------------------------------------
  // Reference model, same cycle timing
  // ----------------------------------------
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {f1, f2, k1, k2, k3, e_rd, e_pin, e_oe} <= '0;
      e_al <= 1'b1;
    end else begin
      f1 <= pri | (f1 & {7{!(rd && addr == 8'h41)}});
      f2 <= sec | (f2 & {8{!(rd && addr == 8'h42)}});
      if (wr && addr == 8'h74) k1 <= wdata;
      if (wr && addr == 8'h75) k2 <= wdata;
      if (wr && addr == 8'h78) k3 <= wdata;
      if (rd) e_rd <= addr == 8'h41 ? {|f2, f1} : addr == 8'h42 ? f2 :
        addr == 8'h74 ? k1 : addr == 8'h75 ? k2 :
        addr == 8'h78 ? k3 : 8'h00;
      e_al <= !pend(f1, f2);
      e_pin <= k3[0] ? 1'b0 : fan;
      e_oe <= k3[0] ? pend(f1, f2) : 1'b1;
    end
  end
  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  always @(negedge clk_i) begin
    if (resetn_i) begin
      chk("rdata", rdata, e_rd);
      chk("al", 8'(alert_n), 8'(e_al));
      chk("pin", {6'h00, oe, pin}, {6'h00, e_oe, e_pin});
    end
  end
  task automatic pulse(input logic [6:0] p, input logic [7:0] s);
    @(posedge clk_i) #1;
    pri = p;
    sec = s;
    i_lam_host_model.rd(8'h41, q);
    i_lam_host_model.rd(8'h42, q);
    pri = 7'h00;
    sec = 8'h00;
    repeat (3) @(posedge clk_i);
    i_lam_host_model.rd(8'h41, q);
    i_lam_host_model.rd(8'h42, q);
  endtask
  task automatic wrap_up();
    if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    // Reset values, read-only status, eight unmapped places
    i_lam_host_model.wr(8'h41, 8'hFF);
    foreach (k1[i]) i_lam_host_model.rd(8'h40 + 8'(i * 15), q);
    i_lam_host_model.rd(8'h74, q);
    i_lam_host_model.rd(8'h75, q);
    i_lam_host_model.rd(8'h78, q);
    pulse(7'h7F, 8'h00);
    // Alert mode, each mask bit alone, with and without enable, secondary bit 7 only with enable
    i_lam_host_model.wr(8'h78, 8'h01);
    for (int j = 0; j < 16; j++) begin
      m = 8'h01 << (j % 8);
      i_lam_host_model.wr(8'h74, (j < 8 ? 8'h80 : 8'h00) | m);
      i_lam_host_model.wr(8'h75, m);
      pulse(m[6:0], m);
    end
    i_lam_host_model.wr(8'h74, 8'h00);
    i_lam_host_model.wr(8'h75, 8'h00);
    repeat (300) begin
      @(posedge clk_i) #1;
      r = $random(seed) & $random(seed) & $random(seed);
      pri = r[6:0];
      sec = r[15:8];
      fan = r[16] ^ r[31];
      r = $random(seed);
      if (r[2:0] == 3'h0) i_lam_host_model.wr(8'h78, r[15:8]);
      repeat (r[6:4]) @(posedge clk_i);
      i_lam_host_model.service();
    end
    wrap_up();
  end
endmodule // lam_alert_top_tb
`default_nettype wire
